// ### rtl/status_flags_pkg.sv
// Package with register map, field positions, reset values and encodings of the status and fault block.
package status_flags_pkg;
   localparam logic [11:0] OFS_STATUS_WORD  = 12'h000;
   localparam logic [11:0] OFS_MODE_CTRL    = 12'h004;
   localparam logic [11:0] OFS_INT_STATE    = 12'h008;
   localparam logic [11:0] OFS_COPROC_EN    = 12'h00c;
   localparam logic [11:0] OFS_COPROC_PRES  = 12'h010;
   localparam logic [11:0] OFS_FAULT_STATUS = 12'h014;

   localparam int BIT_NEG  = 31;
   localparam int BIT_ZERO = 30;
   localparam int BIT_CARRY = 29;
   localparam int BIT_OVF  = 28;
   localparam int BIT_SAT  = 27;
   localparam int GE_LSB   = 16;
   localparam int GE_W     = 4;

   localparam int BIT_UNPRIV   = 0;
   localparam int BIT_DEFER_SET = 28;
   localparam int BIT_DEFER_CLR = 27;

   localparam int BIT_F_ABSENT_COPROCESSOR_FAULT   = 0;
   localparam int BIT_F_UNDEF  = 1;
   localparam int BIT_F_STATE  = 2;
   localparam int BIT_F_SVC    = 3;
   localparam int BIT_F_DBG    = 4;
   localparam int BIT_F_IMPREC = 5;
   localparam int FAULT_W      = 6;

   localparam int NUM_COPROC   = 16;
   localparam logic [3:0] FP_COPROC_LOW  = 4'ha;
   localparam logic [3:0] FP_COPROC_HIGH = 4'hb;

   localparam logic [31:0] STATUS_RESET  = 32'h0000_0000;
   localparam logic [15:0] COPROC_EN_RST = 16'h0000;
   localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

   typedef enum logic [1:0] {
      FLAG_NONE,
      FLAG_ADD,
      FLAG_SUB,
      FLAG_LOGIC
   } flag_op_t;

   typedef enum logic {
      MODE_THREAD,
      MODE_HANDLER
   } exec_mode_t;
endpackage

// ### rtl/status_flags_and_fault_causes.sv
// Status flag word, execution mode and exception cause logic with an APB register slave.
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ps
// What this block does
// - Negative flag takes result bit 31 on a flag-setting instruction.
// - Zero flag is one for an all-zero result, else zero.
// - Carry flag is set when a flag-setting instruction produces carry.
// - Overflow flag is set on signed overflow of a flag-setting instruction.
// - Saturation flag sticks at one when a clamp instruction alters its input.
// - With signal-processing option, multiply overflow also sets saturation.
// - With signal-processing option, lane results update the four greater-equal flags.
// - Without the option, greater-equal positions are reserved and read zero.
// - Reset enters thread mode; privilege follows configuration.
// - Handlers run in handler mode and always privileged.
// - Supervisor call instruction in thread mode raises supervisor-call exception.
// - Deferred service pends only by writing its set bit.
// - Undefined instruction or execution-state error raises misuse fault.
// - Debug events, breakpoint included, raise debug watch exception.
// - Interrupts are treated as asynchronous to the instruction stream.
// - Faults report with their instruction; some system errors report imprecisely.
// - Sixteen coprocessor slots; without support all are absent.
// - Instruction to absent or disabled coprocessor raises absent-coprocessor fault.
// - Unknown instruction to a present, enabled coprocessor raises unknown-op fault.
// - Subtraction carry is one exactly when no unsigned borrow occurs.
module status_flags_and_fault_causes
   import status_flags_pkg::*;
#(
   parameter bit          DSP_PRESENT    = 1'b1,
   parameter bit          COPROC_SUPPORT = 1'b1,
   parameter logic [15:0] COPROC_PRESENT = 16'h0c00
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   input  wire logic        instr_done,
   input  wire flag_op_t    instr_flag_op,
   input  wire logic [31:0] instr_op_a,
   input  wire logic [31:0] instr_op_b,
   input  wire logic        instr_carry_in,
   input  wire logic [31:0] instr_logic_result,
   input  wire logic        instr_logic_carry,
   input  wire logic        clamp_altered,
   input  wire logic        mult_overflow,
   input  wire logic        lane_update,
   input  wire logic [3:0]  lane_ge_results,
   input  wire logic        supervisor_call_instr,
   input  wire logic        undefined_instr,
   input  wire logic        exec_state_error,
   input  wire logic        breakpoint_instr,
   input  wire logic        debug_event,
   input  wire logic        imprecise_error,
   input  wire logic        coproc_instr,
   input  wire logic [3:0]  coproc_num,
   input  wire logic        coproc_unknown,
   input  wire logic        handler_enter,
   input  wire logic        handler_return,
   output logic [31:0]      program_status_word,
   output logic             handler_mode,
   output logic             privileged,
   output logic             svc_exception,
   output logic             deferred_service_exception,
   output logic             misuse_fault,
   output logic             absent_coprocessor_fault,
   output logic             unknown_op_fault,
   output logic             debug_watch_exception,
   output logic             fault_precise,
   output logic             imprecise_fault
);

   function automatic logic [32:0] add_carry(input logic [31:0] a, input logic [31:0] b, input logic cin);
      add_carry = {1'b0, a} + {1'b0, b} + {32'h0000_0000, cin};
   endfunction

   function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] ofs);
      reg_hit = (addr == ofs);
   endfunction

   logic [31:0]         status_q;
   exec_mode_t          mode_q;
   logic                unpriv_q;
   logic                defer_pend_q;
   logic [15:0]         coproc_en_q;
   logic [FAULT_W-1:0]  fault_q;
   logic [31:0]         prdata_q;
   logic [31:0]         status_d;
   logic [32:0]         sum;
   logic [31:0]         op_b;
   logic [31:0]         res;
   logic                cout;
   logic                ovf;
   logic                wr_acc;
   logic                rd_acc;
   logic                mapped;
   logic [15:0]         coproc_avail;
   logic                cp_absent;
   logic                cp_unknown;
   logic                thread_svc;
   logic                deferred_set_wr;

   assign wr_acc = psel & penable & pwrite;
   assign rd_acc = psel & penable & ~pwrite;
   assign pready = 1'b1;
   assign mapped = reg_hit(paddr, OFS_STATUS_WORD) | reg_hit(paddr, OFS_MODE_CTRL)
                 | reg_hit(paddr, OFS_INT_STATE) | reg_hit(paddr, OFS_COPROC_EN)
                 | reg_hit(paddr, OFS_COPROC_PRES) | reg_hit(paddr, OFS_FAULT_STATUS);
   assign pslverr = psel & penable & ~mapped;
   assign prdata = prdata_q;

   // Subtraction adds the inverted operand so carry acts as not-borrow.
   assign op_b = (instr_flag_op == FLAG_SUB) ? ~instr_op_b : instr_op_b;
   assign sum  = add_carry(instr_op_a, op_b, instr_carry_in);
   assign res  = (instr_flag_op == FLAG_LOGIC) ? instr_logic_result : sum[31:0];
   assign cout = (instr_flag_op == FLAG_LOGIC) ? instr_logic_carry : sum[32];
   assign ovf  = (instr_flag_op != FLAG_LOGIC) & (instr_op_a[31] == op_b[31]) & (sum[31] != instr_op_a[31]);

   always_comb begin
      status_d = status_q;
      if (instr_done && instr_flag_op != FLAG_NONE) begin
         status_d[BIT_NEG]   = res[31];
         status_d[BIT_ZERO]  = (res == 32'h0000_0000);
         status_d[BIT_CARRY] = cout;
         if (instr_flag_op != FLAG_LOGIC) begin
            status_d[BIT_OVF] = ovf;
         end
      end
      if (instr_done && lane_update && DSP_PRESENT) begin
         status_d[GE_LSB +: GE_W] = lane_ge_results;
      end
      if (wr_acc && reg_hit(paddr, OFS_STATUS_WORD)) begin
         status_d[BIT_NEG:BIT_SAT] = pwdata[BIT_NEG:BIT_SAT];
         if (DSP_PRESENT) begin
            status_d[GE_LSB +: GE_W] = pwdata[GE_LSB +: GE_W];
         end
      end
      // Hardware saturation wins over a software clear in the same cycle.
      if (instr_done && (clamp_altered || (DSP_PRESENT && mult_overflow))) begin
         status_d[BIT_SAT] = 1'b1;
      end
      if (!DSP_PRESENT) begin
         status_d[GE_LSB +: GE_W] = 4'h0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_q <= STATUS_RESET;
      end else begin
         status_q <= status_d;
      end
   end
   assign program_status_word = status_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= MODE_THREAD;
      end else if (handler_enter) begin
         mode_q <= MODE_HANDLER;
      end else if (handler_return) begin
         mode_q <= MODE_THREAD;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         unpriv_q <= 1'b0;
      end else if (wr_acc && reg_hit(paddr, OFS_MODE_CTRL) && mode_q == MODE_THREAD) begin
         unpriv_q <= pwdata[BIT_UNPRIV];
      end
   end
   assign handler_mode = (mode_q == MODE_HANDLER);
   assign privileged   = handler_mode | ~unpriv_q;

   assign deferred_set_wr = wr_acc & reg_hit(paddr, OFS_INT_STATE) & pwdata[BIT_DEFER_SET];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         defer_pend_q <= 1'b0;
      end else if (deferred_set_wr) begin
         defer_pend_q <= 1'b1;
      end else if (wr_acc && reg_hit(paddr, OFS_INT_STATE) && pwdata[BIT_DEFER_CLR]) begin
         defer_pend_q <= 1'b0;
      end
   end
   assign deferred_service_exception = defer_pend_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         coproc_en_q <= COPROC_EN_RST;
      end else if (wr_acc && reg_hit(paddr, OFS_COPROC_EN)) begin
         coproc_en_q <= pwdata[NUM_COPROC-1:0];
      end
   end

   assign coproc_avail = COPROC_SUPPORT ? COPROC_PRESENT : 16'h0000;
   assign cp_absent  = instr_done & coproc_instr
                     & ~(coproc_avail[coproc_num] & coproc_en_q[coproc_num]);
   assign cp_unknown = instr_done & coproc_instr & coproc_unknown
                     & coproc_avail[coproc_num] & coproc_en_q[coproc_num];
   assign thread_svc = instr_done & supervisor_call_instr & (mode_q == MODE_THREAD);

   // Synchronous causes pulse in the cycle their instruction completes.
   assign svc_exception            = thread_svc;
   assign absent_coprocessor_fault = cp_absent;
   assign unknown_op_fault         = cp_unknown | (instr_done & undefined_instr & ~coproc_instr);
   assign misuse_fault             = absent_coprocessor_fault | unknown_op_fault
                                   | (instr_done & exec_state_error);
   assign debug_watch_exception    = debug_event | (instr_done & breakpoint_instr);
   assign fault_precise            = misuse_fault;
   assign imprecise_fault          = imprecise_error;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_q <= '0;
      end else begin
         for (int i = 0; i < FAULT_W; i++) begin
            if (wr_acc && reg_hit(paddr, OFS_FAULT_STATUS) && pwdata[i]) begin
               fault_q[i] <= 1'b0;
            end
         end
         if (cp_absent) fault_q[BIT_F_ABSENT_COPROCESSOR_FAULT] <= 1'b1;
         if (unknown_op_fault) fault_q[BIT_F_UNDEF] <= 1'b1;
         if (instr_done && exec_state_error) fault_q[BIT_F_STATE] <= 1'b1;
         if (thread_svc) fault_q[BIT_F_SVC] <= 1'b1;
         if (debug_watch_exception) fault_q[BIT_F_DBG] <= 1'b1;
         if (imprecise_error) fault_q[BIT_F_IMPREC] <= 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         unique case (1'b1)
            reg_hit(paddr, OFS_STATUS_WORD):  prdata_q <= status_q;
            reg_hit(paddr, OFS_MODE_CTRL):    prdata_q <= {30'h0, handler_mode, unpriv_q};
            reg_hit(paddr, OFS_INT_STATE):    prdata_q <= {3'h0, defer_pend_q, 28'h000_0000};
            reg_hit(paddr, OFS_COPROC_EN):    prdata_q <= {16'h0000, coproc_en_q};
            reg_hit(paddr, OFS_COPROC_PRES):  prdata_q <= {16'h0000, coproc_avail};
            reg_hit(paddr, OFS_FAULT_STATUS): prdata_q <= {26'h0, fault_q};
            default:                          prdata_q <= UNMAPPED_DATA;
         endcase
      end
   end

   sequence s_flag_instr;
      instr_done && instr_flag_op != FLAG_NONE && !(psel && penable && pwrite);
   endsequence

   chk_neg_from_msb: assert property (@(posedge pclk) disable iff (!presetn)
      s_flag_instr |=> program_status_word[BIT_NEG] == $past(res[31]))
      else $error("negative flag not taken from result msb");
   chk_zero_flag: assert property (@(posedge pclk) disable iff (!presetn)
      s_flag_instr |=> program_status_word[BIT_ZERO] == ($past(res) == 32'h0000_0000))
      else $error("zero flag wrong");
   chk_carry_flag: assert property (@(posedge pclk) disable iff (!presetn)
      s_flag_instr |=> program_status_word[BIT_CARRY] == $past(cout))
      else $error("carry flag wrong");
   chk_sub_not_borrow: assert property (@(posedge pclk) disable iff (!presetn)
      s_flag_instr ##0 (instr_flag_op == FLAG_SUB && instr_carry_in)
      |=> program_status_word[BIT_CARRY] == ($past(instr_op_a) >= $past(instr_op_b)))
      else $error("subtract carry is not not-borrow");
   chk_ovf_flag: assert property (@(posedge pclk) disable iff (!presetn)
      s_flag_instr ##0 instr_flag_op == FLAG_ADD
      |=> program_status_word[BIT_OVF] == ($past(instr_op_a[31]) == $past(instr_op_b[31])
                                         && $past(res[31]) != $past(instr_op_a[31])))
      else $error("overflow flag wrong");
   chk_sat_sticky: assert property (@(posedge pclk) disable iff (!presetn)
      instr_done && clamp_altered |=> program_status_word[BIT_SAT])
      else $error("saturation flag not set");
   chk_ge_update: assert property (@(posedge pclk) disable iff (!presetn)
      instr_done && lane_update && DSP_PRESENT && !(psel && penable && pwrite)
      |=> program_status_word[GE_LSB +: GE_W] == $past(lane_ge_results))
      else $error("greater-equal flags not updated");
   chk_flags_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !instr_done && !(psel && penable && pwrite) |=> $stable(program_status_word))
      else $error("flags changed without an instruction");
   chk_handler_priv: assert property (@(posedge pclk) disable iff (!presetn)
      handler_enter |=> handler_mode && privileged)
      else $error("handler not privileged");
   chk_svc_thread: assert property (@(posedge pclk) disable iff (!presetn)
      instr_done && supervisor_call_instr && !handler_mode |-> svc_exception)
      else $error("supervisor call not raised");
   chk_defer_only_set: assert property (@(posedge pclk) disable iff (!presetn)
      !deferred_service_exception && !deferred_set_wr |=> !deferred_service_exception)
      else $error("deferred service pended without set write");
   chk_absent_coprocessor_fault_fault: assert property (@(posedge pclk) disable iff (!presetn)
      instr_done && coproc_instr && !coproc_en_q[coproc_num] |-> absent_coprocessor_fault && misuse_fault)
      else $error("absent coprocessor fault missing");

   // A bus write of the status word wins over an instruction update in the same cycle, except for a saturation set, which wins.
   sequence s_status_write;
      wr_acc && reg_hit(paddr, OFS_STATUS_WORD);
   endsequence

   sequence s_quiet_instr;
      instr_done && instr_flag_op == FLAG_NONE && !lane_update && !clamp_altered && !mult_overflow;
   endsequence

   chk_unmapped_read: assert property (@(posedge pclk) disable iff (!presetn)
      rd_acc && !mapped
      |-> prdata == UNMAPPED_DATA && pslverr)
      else $error("unmapped read not refused");

   chk_status_write: assert property (@(posedge pclk) disable iff (!presetn)
      s_status_write
      |=> program_status_word[BIT_NEG:BIT_OVF] == $past(pwdata[BIT_NEG:BIT_OVF]))
      else $error("status word write lost");

   chk_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
      program_status_word[BIT_SAT-1:GE_LSB+GE_W] == '0 && program_status_word[GE_LSB-1:0] == '0
      && (DSP_PRESENT || program_status_word[GE_LSB +: GE_W] == '0))
      else $error("reserved status bits not zero");

   chk_sat_multiply: assert property (@(posedge pclk) disable iff (!presetn)
      instr_done && mult_overflow && DSP_PRESENT |=> program_status_word[BIT_SAT])
      else $error("multiply overflow did not saturate");

   chk_flags_none: assert property (@(posedge pclk) disable iff (!presetn)
      s_quiet_instr ##0 !wr_acc
      |=> $stable(program_status_word))
      else $error("flags changed by a non-flag instruction");

   // Checked without a disable so that the reset state itself is seen.
   chk_reset_thread: assert property (@(posedge pclk)
      !presetn && !$past(presetn) |-> !handler_mode && privileged)
      else $error("reset did not select privileged thread mode");

   chk_return_thread: assert property (@(posedge pclk) disable iff (!presetn)
      handler_return && !handler_enter |=> !handler_mode)
      else $error("return did not restore thread mode");

   chk_unpriv_locked: assert property (@(posedge pclk) disable iff (!presetn)
      wr_acc && reg_hit(paddr, OFS_MODE_CTRL) && handler_mode |=> $stable(unpriv_q))
      else $error("privilege changed from handler mode");

   chk_svc_handler_quiet: assert property (@(posedge pclk) disable iff (!presetn)
      handler_mode |-> !svc_exception)
      else $error("supervisor call raised in handler mode");

   chk_defer_pends: assert property (@(posedge pclk) disable iff (!presetn)
      deferred_set_wr |=> deferred_service_exception)
      else $error("deferred service not pended");

   chk_misuse_causes: assert property (@(posedge pclk) disable iff (!presetn)
      instr_done && (undefined_instr || exec_state_error)
      |-> misuse_fault && fault_precise)
      else $error("misuse fault missing");

   chk_debug_raise: assert property (@(posedge pclk) disable iff (!presetn)
      debug_event || (instr_done && breakpoint_instr)
      |-> debug_watch_exception)
      else $error("debug watch exception missing");

   chk_imprecise_logged: assert property (@(posedge pclk) disable iff (!presetn)
      imprecise_error |=> fault_q[BIT_F_IMPREC])
      else $error("imprecise error not logged");

   chk_absent_slot: assert property (@(posedge pclk) disable iff (!presetn)
      instr_done && coproc_instr && !coproc_avail[coproc_num] |-> absent_coprocessor_fault)
      else $error("missing coprocessor slot not absent");

   chk_unknown_enabled: assert property (@(posedge pclk) disable iff (!presetn)
      instr_done && coproc_instr && coproc_unknown && coproc_avail[coproc_num] && coproc_en_q[coproc_num]
      |-> unknown_op_fault && !absent_coprocessor_fault)
      else $error("unknown coprocessor instruction not raised");
endmodule

// ### verification/exc_ctrl_model.sv
// Behavioural exception controller that enters a handler on a supervisor call, misuse, debug watch or deferred service cause and returns on request.
`timescale 1ns/1ps
module exc_ctrl_model #(
   parameter int ENTER_DELAY = 2
) (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic svc_exception,
   input  wire logic misuse_fault,
   input  wire logic debug_watch_exception,
   input  wire logic deferred_service_exception,
   input  wire logic ret_req,
   output logic      handler_enter,
   output logic      handler_return
);
   logic in_handler_q;
   logic armed_q;
   int   wait_q;
   // A pending deferred request is taken like any other cause; once armed, entry follows even if its level drops.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {in_handler_q, armed_q, handler_enter, handler_return} <= '0;
         wait_q <= 0;
      end else begin
         handler_enter <= 1'b0;
         handler_return <= 1'b0;
         if (!in_handler_q && !armed_q &&
             (svc_exception || misuse_fault || debug_watch_exception || deferred_service_exception)) begin
            armed_q <= 1'b1;
            wait_q <= ENTER_DELAY;
         end else if (armed_q && wait_q > 1) begin
            wait_q <= wait_q - 1;
         end else if (armed_q) begin
            armed_q <= 1'b0;
            in_handler_q <= 1'b1;
            handler_enter <= 1'b1;
         end else if (in_handler_q && ret_req) begin
            in_handler_q <= 1'b0;
            handler_return <= 1'b1;
         end
      end
   end
endmodule

// ### verification/testbench.sv
// Self-checking bench for the status flag, execution mode and fault cause block.
`timescale 1ns/1ps
module testbench
   import status_flags_pkg::*;
;
   typedef struct {flag_op_t op; logic [31:0] a, b; logic cin; logic [3:0] nzcv;} row_t;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, instr_done, instr_carry_in, err;
   logic        instr_logic_carry, clamp_altered, mult_overflow, lane_update, supervisor_call_instr;
   logic        undefined_instr, exec_state_error, breakpoint_instr, debug_event, imprecise_error;
   logic        coproc_instr, coproc_unknown, handler_enter, handler_return, ret_req, handler_mode;
   logic        privileged, svc_exception, deferred_service_exception, misuse_fault, imprecise_fault;
   logic        absent_coprocessor_fault, unknown_op_fault, debug_watch_exception, fault_precise, ab;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, instr_op_a, instr_op_b, instr_logic_result, program_status_word, rd;
   logic [3:0]  lane_ge_results, coproc_num;
   logic [15:0] ens [3] = '{16'h0000, 16'h0c00, 16'hffff};
   flag_op_t    instr_flag_op;
   localparam logic [15:0] COPROC_PRESENT = 16'h0c00;
   int          mismatches = 0, num_checks = 0, cyc = 0;
   row_t        rows [8] = '{
      '{FLAG_ADD, 32'h7fffffff, 32'h00000001, 1'b0, 4'h9}, '{FLAG_ADD, 32'hffffffff, 32'h00000001, 1'b0, 4'h6},
      '{FLAG_SUB, 32'h00000005, 32'h00000005, 1'b1, 4'h6}, '{FLAG_SUB, 32'h00000003, 32'h00000005, 1'b1, 4'h8},
      '{FLAG_SUB, 32'h00000005, 32'h00000003, 1'b0, 4'h2}, '{FLAG_SUB, 32'h80000000, 32'h00000001, 1'b1, 4'h3},
      '{FLAG_LOGIC, 32'h00000000, 32'h00000000, 1'b1, 4'h7}, '{FLAG_NONE, 32'hffffffff, 32'h0, 1'b0, 4'h7}};

   status_flags_and_fault_causes dut_u (.*);
   exc_ctrl_model partner_u (.*);

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic chkb(input string n, input logic e, input logic g);
      chk(n, {31'h0, e}, {31'h0, g});
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         mismatches++;
         report_and_stop;
      end
   end

   task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      chkb("pready", 1'b1, pready);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge pclk);
   endtask

   task automatic zero;
      {instr_done, clamp_altered, mult_overflow, lane_update, supervisor_call_instr, undefined_instr,
       exec_state_error, breakpoint_instr, debug_event, imprecise_error, coproc_instr, coproc_unknown} <= '0;
      {instr_op_a, instr_op_b, instr_carry_in, instr_logic_result, instr_logic_carry} <= '0;
      {lane_ge_results, coproc_num} <= '0;
      instr_flag_op <= FLAG_NONE;
   endtask

   task automatic clr;
      @(posedge pclk);
      zero;
      @(negedge pclk);
   endtask

   task automatic wait_h(input logic v);
      repeat (10) if (handler_mode !== v) @(negedge pclk);
   endtask

   task automatic settle;
      repeat (4) @(posedge pclk);
      ret_req <= 1'b1;
      @(posedge pclk);
      ret_req <= 1'b0;
      wait_h(1'b0);
   endtask

   task automatic svc_pulse(input logic e);
      @(posedge pclk);
      instr_done <= 1'b1;
      supervisor_call_instr <= 1'b1;
      @(negedge pclk);
      chkb("svc", e, svc_exception);
      clr;
   endtask

   initial begin
      {psel, penable, pwrite, paddr, pwdata, ret_req, presetn} = '0;
      zero;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      chk("status", STATUS_RESET, program_status_word);
      chkb("handler", 1'b0, handler_mode);
      chkb("priv", 1'b1, privileged);
      foreach (rows[i]) begin
         @(posedge pclk);
         instr_done <= 1'b1;
         instr_flag_op <= rows[i].op;
         instr_op_a <= rows[i].a;
         instr_logic_result <= rows[i].a;
         instr_op_b <= rows[i].b;
         instr_carry_in <= rows[i].cin;
         instr_logic_carry <= rows[i].cin;
         clr;
         chk("nzcv", {28'h0, rows[i].nzcv}, {28'h0, program_status_word[31:28]});
      end
      @(posedge pclk);
      instr_done <= 1'b1;
      clamp_altered <= 1'b1;
      lane_update <= 1'b1;
      lane_ge_results <= 4'ha;
      clr;
      chkb("sat", 1'b1, program_status_word[BIT_SAT]);
      chk("ge", 32'ha, {28'h0, program_status_word[19:16]});
      apb(1'b0, OFS_STATUS_WORD, 32'h0);
      chk("status read", 32'h780a0000, rd);
      apb(1'b1, OFS_STATUS_WORD, rd & ~32'h08000000);
      chkb("sat clear", 1'b0, program_status_word[BIT_SAT]);
      @(posedge pclk);
      instr_done <= 1'b1;
      mult_overflow <= 1'b1;
      clr;
      chkb("sat mult", 1'b1, program_status_word[BIT_SAT]);
      chk("ge kept", 32'ha, {28'h0, program_status_word[19:16]});
      apb(1'b0, 12'h020, 32'h0);
      chkb("slverr", 1'b1, err);
      chk("unmapped", UNMAPPED_DATA, rd);
      svc_pulse(1'b1);
      wait_h(1'b1);
      chkb("handler", 1'b1, handler_mode);
      svc_pulse(1'b0);
      settle;
      apb(1'b1, OFS_MODE_CTRL, 32'h1);
      chkb("unpriv", 1'b0, privileged);
      svc_pulse(1'b1);
      wait_h(1'b1);
      chkb("handler priv", 1'b1, privileged);
      apb(1'b1, OFS_MODE_CTRL, 32'h0);
      settle;
      chkb("thread unpriv", 1'b0, privileged);
      apb(1'b1, OFS_MODE_CTRL, 32'h0);
      chkb("defer idle", 1'b0, deferred_service_exception);
      apb(1'b1, OFS_INT_STATE, 32'h1 << BIT_DEFER_SET);
      chkb("defer set", 1'b1, deferred_service_exception);
      wait_h(1'b1);
      apb(1'b1, OFS_INT_STATE, 32'h1 << BIT_DEFER_CLR);
      chkb("defer clear", 1'b0, deferred_service_exception);
      settle;
      for (int k = 0; k < 5; k++) begin
         @(posedge pclk);
         instr_done <= 1'b1;
         case (k)
            0: undefined_instr <= 1'b1;
            1: exec_state_error <= 1'b1;
            2: breakpoint_instr <= 1'b1;
            3: debug_event <= 1'b1;
            default: imprecise_error <= 1'b1;
         endcase
         @(negedge pclk);
         chkb("misuse", k < 2, misuse_fault);
         chkb("precise", k < 2, fault_precise);
         chkb("debug", k == 2 || k == 3, debug_watch_exception);
         chkb("imprecise", k == 4, imprecise_fault);
         clr;
         settle;
      end
      foreach (ens[j]) begin
         apb(1'b1, OFS_COPROC_EN, {16'h0, ens[j]});
         for (int s = 0; s < NUM_COPROC; s++) begin
            @(posedge pclk);
            instr_done <= 1'b1;
            coproc_instr <= 1'b1;
            coproc_num <= 4'(s);
            coproc_unknown <= s[0];
            @(negedge pclk);
            ab = !(COPROC_PRESENT[s] && ens[j][s]);
            chkb("absent", ab, absent_coprocessor_fault);
            chkb("unknown", !ab && s[0], unknown_op_fault);
            clr;
         end
         settle;
      end
      apb(1'b0, OFS_FAULT_STATUS, 32'h0);
      chk("faults", 32'h3f, rd);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      chk("status rst", STATUS_RESET, program_status_word);
      chkb("handler rst", 1'b0, handler_mode);
      apb(1'b0, OFS_FAULT_STATUS, 32'h0);
      chk("faults rst", 32'h0, rd);
      report_and_stop;
   end
endmodule
